// file: inc/mbox_pkg.sv
// Shared constants, carriers and slot arithmetic for the mailbox block.
// Assumes a single 125 MHz clock and word-wide register accesses.
package mbox_pkg;
  localparam int DW = 32;
  localparam int PTR_W = 8;
  localparam int RING_DEPTH = 32;
  // Register offsets; 00h-0ch on both register ports, 10h and 14h engine port only, 40h host config space
  localparam logic [7:0] OFS_WIN = 8'h00;
  localparam logic [7:0] OFS_OWN_CSR = 8'h04;
  localparam logic [7:0] OFS_PEER_CSR = 8'h08;
  localparam logic [7:0] OFS_RD_WIN = 8'h0c;
  localparam logic [7:0] OFS_HDEPTH = 8'h10;
  localparam logic [7:0] OFS_FWSTAT = 8'h14;
  localparam logic [7:0] OFS_CFG_FWSTAT = 8'h40;
  // Control/status word layout
  localparam int BIT_IE = 0;
  localparam int BIT_IS = 1;
  localparam int BIT_IG = 2;
  localparam int BIT_RDY = 3;
  localparam int BIT_RST = 4;
  localparam int BIT_PCLR = 5;
  localparam int CSR_RP_LSB = 8;
  localparam int CSR_WP_LSB = 16;
  localparam int CSR_DEPTH_LSB = 24;
  localparam logic [7:0] DEPTH_DEFAULT = 8'h20;
  localparam logic [31:0] FWSTAT_RESET = 32'h0000_0000;
  localparam int PCLR_MAX_CYCLES = 10;

  typedef struct packed {
    logic wr;
    logic rd;
    logic cfg;
    logic [7:0] addr;
    logic [DW-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ie;
    logic is;
    logic ig;
    logic rdy;
    logic rst;
    logic [PTR_W-1:0] depth;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
  } csr_t;

  typedef struct packed {
    logic h_empty;
    logic h_full;
    logic h_ovf;
    logic e_empty;
    logic e_full;
    logic e_ovf;
  } ring_flags_t;

  // Signed 8-bit difference kept as unsigned 8 bits
  function automatic logic [PTR_W-1:0] ring_filled(logic [PTR_W-1:0] wp, logic [PTR_W-1:0] rp);
    return PTR_W'($signed(wp) - $signed(rp));
  endfunction : ring_filled

  function automatic logic [PTR_W-1:0] ring_empty_slots(csr_t c);
    return PTR_W'(c.depth - ring_filled(c.wp, c.rp));
  endfunction : ring_empty_slots

  function automatic logic [DW-1:0] csr_word(csr_t c, logic pclr);
    logic [DW-1:0] w;
    w = '0;
    w[CSR_DEPTH_LSB +: PTR_W] = c.depth;
    w[CSR_WP_LSB +: PTR_W] = c.wp;
    w[CSR_RP_LSB +: PTR_W] = c.rp;
    w[BIT_IE] = c.ie;
    w[BIT_IS] = c.is;
    w[BIT_IG] = c.ig;
    w[BIT_RDY] = c.rdy;
    w[BIT_RST] = c.rst;
    w[BIT_PCLR] = pclr;
    return w;
  endfunction : csr_word
endpackage : mbox_pkg

// file: rtl/stream_fifo.sv
// Word FIFO with registered read data, used for both ring buffers.
// Assumes DEPTH is a power of two; flush empties it in one cycle.
`timescale 1ns/1ns
module stream_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [W-1:0] dout;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  assign in_ready = s.cnt != FULL;
  assign out_valid = s.cnt != '0;
  assign out_data = s.dout;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_s = s;
    next_s.dout = '0;
    if (push)
    begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = s.wr + AW'(1);
    end
    if (pop)
    begin
      next_s.dout = s.mem[s.rd];
      next_s.rd = s.rd + AW'(1);
    end
    case ({push, pop})
      2'b10: next_s.cnt = s.cnt + (AW+1)'(1);
      2'b01: next_s.cnt = s.cnt - (AW+1)'(1);
      default: next_s.cnt = s.cnt;
    endcase
    // Flush drops contents but still hands out a word popped this cycle
    if (flush)
    begin
      next_s.wr = '0;
      next_s.rd = '0;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule : stream_fifo

// file: rtl/mgmt_mailbox_ring_reset.sv
// Mailbox between host software and management engine: two ring buffers,
// control/status words, reset handling and the firmware status word.
// Assumes both register ports and reset pins are synchronous to ref_clk.
//
// What this block does
// - Engine starts interface reset: ready low, reset request and irq generate high.
// - After partition reset engine registers return to defaults first.
// - Firmware stops ring traffic during reset; hardware discards it anyway.
// - Pointer clear zeroes all pointers; drops while host powered and not reset, or at partition reset.
// - Depths change only while idle; hardware does not check this.
// - Partition reset clears engine word and ready; no ready means traffic dropped.
// - Partition reset restores host depth, leaves other host bits alone.
// - After partition reset engine sends nothing until interface reset ends.
// - Host soft reset clears host-side registers except depth and read pointer and, on the engine side, only the read pointer.
// - Soft reset clears host ready, pointer, irq bits, engine read pointer.
// - Host config space holds a 32-bit firmware status word at 40h.
// - Filled slots are write minus read pointer, kept as unsigned 8 bits.
// - Filled zero is empty, equal depth is full, above depth is overflow.
// - Empty slots are depth minus filled, kept as unsigned 8 bits.
// - Host reset request rising clears engine ready and host ready.
// - Hardware zeroes four pointers then drops pointer clear within ten cycles once host is powered and out of reset.
// - Host irq generate sets engine irq status, interrupts engine, then self-clears.
`timescale 1ns/1ns
module mgmt_mailbox_ring_reset #(
  parameter int RING_DEPTH = mbox_pkg::RING_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic engine_partition_reset_n,
  input wire logic host_soft_reset_n,
  input wire logic host_powered,
  input wire mbox_pkg::reg_req_t host_req,
  output logic [mbox_pkg::DW-1:0] host_rdata,
  input wire mbox_pkg::reg_req_t engine_req,
  output logic [mbox_pkg::DW-1:0] engine_rdata,
  output logic host_irq,
  output logic engine_irq,
  output mbox_pkg::ring_flags_t ring_flags
);
  typedef struct packed {
    mbox_pkg::csr_t hc;
    mbox_pkg::csr_t ec;
    logic pclr;
    logic [mbox_pkg::DW-1:0] fw;
    logic [mbox_pkg::DW-1:0] h_rd;
    logic [mbox_pkg::DW-1:0] e_rd;
    logic h_win;
    logic e_win;
    mbox_pkg::ring_flags_t flags;
  } state_t;

  localparam mbox_pkg::csr_t ENGINE_CSR_RESET = '{
    ie: 1'b0, is: 1'b0, ig: 1'b0, rdy: 1'b0, rst: 1'b0,
    depth: mbox_pkg::DEPTH_DEFAULT, wp: 8'h00, rp: 8'h00};
  localparam mbox_pkg::csr_t HOST_CSR_RESET = ENGINE_CSR_RESET;

  state_t s;
  state_t next_s;
  logic [mbox_pkg::DW-1:0] h_ring_out;
  logic [mbox_pkg::DW-1:0] e_ring_out;
  logic h_ring_in_ready;
  logic e_ring_in_ready;
  logic h_ring_valid;
  logic e_ring_valid;
  logic host_ctrl_status_wr;
  logic e_csr_wr;
  logic h_win_wr;
  logic e_win_wr;
  logic h_win_rd;
  logic e_win_rd;

  // Ring traffic only counts while the engine is ready
  assign h_win_wr = host_req.wr && !host_req.cfg && host_req.addr == mbox_pkg::OFS_WIN
                    && s.ec.rdy;
  assign e_win_rd = engine_req.wr == 1'b0 && engine_req.rd
                    && engine_req.addr == mbox_pkg::OFS_RD_WIN && s.ec.rdy;
  assign e_win_wr = engine_req.wr && engine_req.addr == mbox_pkg::OFS_WIN && s.ec.rdy;
  assign h_win_rd = host_req.rd && !host_req.wr && !host_req.cfg
                    && host_req.addr == mbox_pkg::OFS_RD_WIN && s.ec.rdy;
  assign host_ctrl_status_wr = host_req.wr && !host_req.cfg && host_req.addr == mbox_pkg::OFS_OWN_CSR;
  assign e_csr_wr = engine_req.wr && engine_req.addr == mbox_pkg::OFS_OWN_CSR;

  // Host to engine ring; a full ring drops the word but the pointer still moves,
  // so software sees the overflow in the slot count
  stream_fifo #(.W(mbox_pkg::DW), .DEPTH(RING_DEPTH)) host_ring (
    .ref_clk(ref_clk),
    .srst(srst),
    .flush(s.pclr),
    .in_valid(h_win_wr),
    .in_ready(h_ring_in_ready),
    .in_data(host_req.wdata),
    .out_valid(h_ring_valid),
    .out_ready(e_win_rd),
    .out_data(h_ring_out)
  );

  stream_fifo #(.W(mbox_pkg::DW), .DEPTH(RING_DEPTH)) engine_ring (
    .ref_clk(ref_clk),
    .srst(srst),
    .flush(s.pclr),
    .in_valid(e_win_wr),
    .in_ready(e_ring_in_ready),
    .in_data(engine_req.wdata),
    .out_valid(e_ring_valid),
    .out_ready(h_win_rd),
    .out_data(e_ring_out)
  );

  assign host_irq = s.hc.is && s.hc.ie;
  assign engine_irq = s.ec.is && s.ec.ie;
  assign ring_flags = s.flags;
  assign host_rdata = s.h_win ? e_ring_out : s.h_rd;
  assign engine_rdata = s.e_win ? h_ring_out : s.e_rd;

  always_comb
  begin
    next_s = s;
    // Slot arithmetic on the current words
    next_s.flags.h_empty = mbox_pkg::ring_filled(s.hc.wp, s.hc.rp) == 8'h00;
    next_s.flags.h_full = mbox_pkg::ring_filled(s.hc.wp, s.hc.rp) == s.hc.depth;
    next_s.flags.h_ovf = mbox_pkg::ring_filled(s.hc.wp, s.hc.rp) > s.hc.depth;
    next_s.flags.e_empty = mbox_pkg::ring_filled(s.ec.wp, s.ec.rp) == 8'h00;
    next_s.flags.e_full = mbox_pkg::ring_empty_slots(s.ec) == 8'h00;
    next_s.flags.e_ovf = mbox_pkg::ring_filled(s.ec.wp, s.ec.rp) > s.ec.depth;

    // Host register reads, one cycle latency
    next_s.h_win = h_win_rd;
    next_s.h_rd = '0;
    if (host_req.rd && host_req.cfg && host_req.addr == mbox_pkg::OFS_CFG_FWSTAT)
      next_s.h_rd = s.fw;
    else if (host_req.rd && !host_req.cfg)
    begin
      case (host_req.addr)
        mbox_pkg::OFS_OWN_CSR: next_s.h_rd = mbox_pkg::csr_word(s.hc, 1'b0);
        mbox_pkg::OFS_PEER_CSR: next_s.h_rd = mbox_pkg::csr_word(s.ec, s.pclr);
        default: next_s.h_rd = '0;
      endcase
    end

    // Engine register reads
    next_s.e_win = e_win_rd;
    next_s.e_rd = '0;
    if (engine_req.rd)
    begin
      case (engine_req.addr)
        mbox_pkg::OFS_OWN_CSR: next_s.e_rd = mbox_pkg::csr_word(s.ec, s.pclr);
        mbox_pkg::OFS_PEER_CSR: next_s.e_rd = mbox_pkg::csr_word(s.hc, 1'b0);
        mbox_pkg::OFS_HDEPTH: next_s.e_rd = {s.hc.depth, 24'h00_0000};
        mbox_pkg::OFS_FWSTAT: next_s.e_rd = s.fw;
        default: next_s.e_rd = '0;
      endcase
    end

    // Engine writes; depths are taken as written, idle is software's duty
    if (e_csr_wr)
    begin
      next_s.ec.ie = engine_req.wdata[mbox_pkg::BIT_IE];
      next_s.ec.rdy = engine_req.wdata[mbox_pkg::BIT_RDY];
      next_s.ec.rst = engine_req.wdata[mbox_pkg::BIT_RST];
      next_s.ec.depth = engine_req.wdata[mbox_pkg::CSR_DEPTH_LSB +: mbox_pkg::PTR_W];
      if (engine_req.wdata[mbox_pkg::BIT_IG])
        next_s.ec.ig = 1'b1;
      if (engine_req.wdata[mbox_pkg::BIT_IS])
        next_s.ec.is = 1'b0;
      if (engine_req.wdata[mbox_pkg::BIT_PCLR])
        next_s.pclr = 1'b1;
    end
    if (engine_req.wr && engine_req.addr == mbox_pkg::OFS_HDEPTH)
      next_s.hc.depth = engine_req.wdata[mbox_pkg::CSR_DEPTH_LSB +: mbox_pkg::PTR_W];
    if (engine_req.wr && engine_req.addr == mbox_pkg::OFS_FWSTAT)
      next_s.fw = engine_req.wdata;

    // Host writes; depth is read-only from this side
    if (host_ctrl_status_wr)
    begin
      next_s.hc.ie = host_req.wdata[mbox_pkg::BIT_IE];
      next_s.hc.rdy = host_req.wdata[mbox_pkg::BIT_RDY];
      next_s.hc.rst = host_req.wdata[mbox_pkg::BIT_RST];
      if (host_req.wdata[mbox_pkg::BIT_IG])
        next_s.hc.ig = 1'b1;
      if (host_req.wdata[mbox_pkg::BIT_IS])
        next_s.hc.is = 1'b0;
      if (host_req.wdata[mbox_pkg::BIT_RST] && !s.hc.rst)
      begin
        next_s.ec.rdy = 1'b0;
        next_s.hc.rdy = 1'b0;
      end
    end

    // Pointer moves on accepted window traffic
    if (h_win_wr)
      next_s.hc.wp = s.hc.wp + 8'h01;
    if (e_win_rd)
      next_s.hc.rp = s.hc.rp + 8'h01;
    if (e_win_wr)
      next_s.ec.wp = s.ec.wp + 8'h01;
    if (h_win_rd)
      next_s.ec.rp = s.ec.rp + 8'h01;

    // Generate bits set the peer status then drop; set beats a same-cycle clear
    if (s.hc.ig)
    begin
      next_s.ec.is = 1'b1;
      next_s.hc.ig = 1'b0;
    end
    if (s.ec.ig)
    begin
      next_s.hc.is = 1'b1;
      next_s.ec.ig = 1'b0;
    end

    // Pointer clear: one cycle to zero, release gated by the host
    if (s.pclr)
    begin
      next_s.hc.wp = 8'h00;
      next_s.hc.rp = 8'h00;
      next_s.ec.wp = 8'h00;
      next_s.ec.rp = 8'h00;
      // A fresh set from the engine in the same cycle wins over the release
      if (host_powered && host_soft_reset_n
          && !(e_csr_wr && engine_req.wdata[mbox_pkg::BIT_PCLR]))
        next_s.pclr = 1'b0;
    end

    // Host soft reset leaves host depth and the engine word, except its read pointer, alone
    if (!host_soft_reset_n)
    begin
      next_s.hc.rdy = 1'b0;
      next_s.hc.wp = 8'h00;
      next_s.hc.is = 1'b0;
      next_s.hc.ig = 1'b0;
      next_s.hc.ie = 1'b0;
      next_s.hc.rst = 1'b0;
      next_s.ec.rp = 8'h00;
      next_s.fw = mbox_pkg::FWSTAT_RESET;
      next_s.h_rd = '0;
      next_s.h_win = 1'b0;
    end

    // Partition reset: engine word to defaults, host depth restored
    if (!engine_partition_reset_n)
    begin
      next_s.ec = ENGINE_CSR_RESET;
      next_s.pclr = 1'b0;
      next_s.hc.depth = mbox_pkg::DEPTH_DEFAULT;
      next_s.e_rd = '0;
      next_s.e_win = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s <= '0;
      s.hc <= HOST_CSR_RESET;
      s.ec <= ENGINE_CSR_RESET;
      s.fw <= mbox_pkg::FWSTAT_RESET;
    end
    else
      s <= next_s;
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic quiet;
  assign quiet = engine_partition_reset_n && host_soft_reset_n;

  ig_to_status_a: assert property (
    (host_ctrl_status_wr && host_req.wdata[mbox_pkg::BIT_IG] && quiet)
      |=> s.hc.ig ##1 (s.ec.is || $past(!engine_partition_reset_n)))
    else $error("host generate did not raise engine status");

  eng_request_a: assert property (
    (s.ec.ig && quiet) |=> (s.hc.is && !s.ec.ig))
    else $error("engine generate did not reach host status");

  ptr_zero_a: assert property (
    (s.pclr && quiet)
      |=> (s.hc.wp == 8'h00 && s.hc.rp == 8'h00 && s.ec.wp == 8'h00 && s.ec.rp == 8'h00))
    else $error("pointers not zeroed by pointer clear");

  pclr_release_a: assert property (
    (s.pclr && host_powered && quiet && !e_csr_wr) |=> !s.pclr)
    else $error("pointer clear not released");

  pclr_hold_a: assert property (
    (s.pclr && !host_powered && engine_partition_reset_n) |=> s.pclr)
    else $error("pointer clear dropped while host unpowered");

  host_rst_edge_a: assert property (
    (host_ctrl_status_wr && host_req.wdata[mbox_pkg::BIT_RST] && !s.hc.rst)
      |=> (!s.ec.rdy && !s.hc.rdy))
    else $error("host reset request did not clear ready flags");

  part_reset_a: assert property (
    !engine_partition_reset_n
      |=> (!s.ec.rdy && !s.pclr && s.hc.depth == mbox_pkg::DEPTH_DEFAULT))
    else $error("partition reset incomplete");

  soft_reset_a: assert property (
    (!host_soft_reset_n && engine_partition_reset_n && !engine_req.wr)
      |=> (!host_irq && s.hc.wp == 8'h00 && s.ec.rp == 8'h00
           && s.hc.depth == $past(s.hc.depth)))
    else $error("host soft reset incomplete");

  discard_a: assert property (
    (!s.ec.rdy && !s.pclr && quiet) |=> (s.hc.wp == $past(s.hc.wp)))
    else $error("ring write taken while engine not ready");

  firmware_state_report_a: assert property (
    (host_req.rd && host_req.cfg && host_req.addr == mbox_pkg::OFS_CFG_FWSTAT && quiet)
      |=> host_rdata == $past(s.fw))
    else $error("firmware status read mismatch");

  slot_math_a: assert property (
    ##1 s.flags.h_ovf == ($past(mbox_pkg::ring_filled(s.hc.wp, s.hc.rp)) > $past(s.hc.depth)))
    else $error("overflow flag wrong");

  part_host_keep_a: assert property (
    (!engine_partition_reset_n && host_soft_reset_n && !host_ctrl_status_wr)
      |=> (s.hc.rdy == $past(s.hc.rdy) && s.hc.ie == $past(s.hc.ie)
           && s.hc.rst == $past(s.hc.rst)))
    else $error("partition reset disturbed host control bits");

  rd_discard_a: assert property (
    (!s.ec.rdy && !s.pclr && quiet)
      |=> (s.ec.wp == $past(s.ec.wp) && s.hc.rp == $past(s.hc.rp)
           && s.ec.rp == $past(s.ec.rp)))
    else $error("ring traffic taken while engine not ready");

  pclr_set_wins_a: assert property (
    (e_csr_wr && engine_req.wdata[mbox_pkg::BIT_PCLR] && engine_partition_reset_n) |=> s.pclr)
    else $error("pointer clear request lost");

  pclr_cycle_c: cover property ($rose(s.pclr) ##[1:3] !s.pclr);
  host_reset_c: cover property (host_ctrl_status_wr && host_req.wdata[mbox_pkg::BIT_RST] && s.ec.rdy);
  ring_pass_c: cover property (h_win_wr ##[1:20] e_win_rd);
  ring_full_c: cover property (s.flags.h_full && !h_ring_in_ready);
  soft_reset_c: cover property (!host_soft_reset_n ##1 host_soft_reset_n);
endmodule : mgmt_mailbox_ring_reset

// file: tb/host_model.sv
// Host driver model: register accesses and the host side of the reset handshake.
// Assumes the block takes a request at the rising edge after it is raised.
`timescale 1ns/1ns
module host_model (
  input wire logic ref_clk,
  output mbox_pkg::reg_req_t host_req,
  input wire logic [31:0] host_rdata
);
  initial host_req = '0;

  // Released lines show an inverted address, and inverted data after a write, so stale data is never mistaken for live
  task automatic hw(input logic [7:0] a, input logic [31:0] v);
    @(negedge ref_clk);
    host_req = '{1'b1, 1'b0, 1'b0, a, v};
    @(negedge ref_clk);
    host_req = '{1'b0, 1'b0, 1'b0, ~a, ~v};
  endtask : hw

  task automatic hr(input logic [7:0] a, input logic c, output logic [31:0] v);
    @(negedge ref_clk);
    host_req = '{1'b0, 1'b1, c, a, host_req.wdata};
    @(negedge ref_clk);
    v = host_rdata;
    host_req = '{1'b0, 1'b0, 1'b0, ~a, host_req.wdata};
  endtask : hr

  // Never trusts the link state: reset request, irq generate, irq enable
  task automatic start_reset();
    hw(8'h04, 32'h0000_0015);
  endtask : start_reset

  // Polls engine ready a bounded number of times, then falls back to status
  task automatic wait_ready(input int polls, output logic ok);
    logic [31:0] v;
    ok = 1'b0;
    repeat (polls)
    begin
      hr(8'h08, 1'b0, v);
      ok = ok | v[3];
    end
    if (!ok)
      hr(8'h40, 1'b1, v);
  endtask : wait_ready

  task automatic finish_reset();
    hw(8'h04, 32'h0000_000d);
  endtask : finish_reset

  task automatic going_down();
    hw(8'h04, 32'h0000_0004);
  endtask : going_down
endmodule : host_model

// file: tb/mgmt_mailbox_ring_reset_tb.sv
// Self-checking bench: host model on the host port, engine port driven here.
// Assumes one 125 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
module mgmt_mailbox_ring_reset_tb;
  logic ref_clk;
  logic srst;
  logic engine_partition_reset_n;
  logic host_soft_reset_n;
  logic host_powered;
  mbox_pkg::reg_req_t host_req;
  mbox_pkg::reg_req_t ereq;
  logic [31:0] host_rdata;
  logic [31:0] engine_rdata;
  logic host_irq;
  logic engine_irq;
  mbox_pkg::ring_flags_t ring_flags;
  logic [31:0] d;
  logic [7:0] f;
  logic s;
  int bad_count;
  int n_tests;

  mgmt_mailbox_ring_reset #(.RING_DEPTH(32)) uut (
    .ref_clk(ref_clk),
    .srst(srst),
    .engine_partition_reset_n(engine_partition_reset_n),
    .host_soft_reset_n(host_soft_reset_n),
    .host_powered(host_powered),
    .host_req(host_req),
    .host_rdata(host_rdata),
    .engine_req(ereq),
    .engine_rdata(engine_rdata),
    .host_irq(host_irq),
    .engine_irq(engine_irq),
    .ring_flags(ring_flags)
  );

  host_model host (.ref_clk(ref_clk), .host_req(host_req), .host_rdata(host_rdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic ew(input logic [7:0] a, input logic [31:0] v);
    @(negedge ref_clk);
    ereq = '{1'b1, 1'b0, 1'b0, a, v};
    @(negedge ref_clk);
    ereq = '{1'b0, 1'b0, 1'b0, ~a, ~v};
  endtask : ew

  task automatic er(input logic [7:0] a, output logic [31:0] v);
    @(negedge ref_clk);
    ereq = '{1'b0, 1'b1, 1'b0, a, ereq.wdata};
    @(negedge ref_clk);
    v = engine_rdata;
    ereq.rd = 1'b0;
  endtask : er

  task automatic t_reset();
    host.hr(8'h04, 1'b0, d);
    chk("host_csr", 32'h2000_0000, d);
    er(8'h04, d);
    chk("engine_csr", 32'h2000_0000, d);
    host.hr(8'h40, 1'b1, d);
    chk("firmware_state_report", 32'h0, d);
    host.hr(8'h1c, 1'b0, d);
    chk("unmapped", 32'h0, d);
  endtask : t_reset

  task automatic t_engine_reset();
    ew(8'h04, 32'h2000_0014);
    host.hr(8'h08, 1'b0, d);
    chk("engine_view", 32'h2000_0010, d);
    host.start_reset();
    chk("host_irq", 32'h1, {31'h0, host_irq});
    ew(8'h04, 32'h2000_0020);
    repeat (mbox_pkg::PCLR_MAX_CYCLES - 2) @(negedge ref_clk);
    er(8'h04, d);
    chk("pclr_drop", 32'h0, d & 32'h0000_0020);
    ew(8'h04, 32'h2000_000f);
    host.wait_ready(2, s);
    chk("ready_seen", 32'h1, {31'h0, s});
    chk("engine_irq_idle", 32'h0, {31'h0, engine_irq});
    host.finish_reset();
    @(negedge ref_clk);
    chk("engine_irq", 32'h1, {31'h0, engine_irq});
    host.hr(8'h04, 1'b0, d);
    chk("host_ig_clear", 32'h2000_0009, d & 32'hff00_000d);
  endtask : t_engine_reset

  // Fill past the top, check arithmetic, read the first two words in order, then clear pointers
  task automatic t_ring();
    for (int i = 0; i < 32; i++)
      host.hw(8'h00, 32'(i + 1));
    @(negedge ref_clk);
    chk("full", 32'h1, {31'h0, ring_flags.h_full});
    host.hw(8'h00, 32'hdead_beef);
    er(8'h08, d);
    f = d[23:16] - d[15:8];
    chk("filled", 32'h21, {24'h0, f});
    chk("empty_slots", 32'hff, {24'h0, d[31:24] - f});
    chk("overflow", 32'h1, {31'h0, ring_flags.h_ovf});
    er(8'h0c, d);
    chk("word0", 32'h1, d);
    er(8'h0c, d);
    chk("word1", 32'h2, d);
    host_powered = 1'b0;
    ew(8'h04, 32'h2000_0029);
    repeat (12) @(negedge ref_clk);
    er(8'h04, d);
    chk("pclr_hold", 32'h20, d & 32'h0000_0020);
    host_powered = 1'b1;
    repeat (mbox_pkg::PCLR_MAX_CYCLES - 2) @(negedge ref_clk);
    er(8'h04, d);
    chk("pclr_clear", 32'h0, d & 32'h0000_0020);
    host.hr(8'h04, 1'b0, d);
    chk("ptrs_zero", 32'h0, d & 32'h00ff_ff00);
    chk("empty", 32'h1, {31'h0, ring_flags.h_empty});
    chk("e_flags", 32'h4, {29'h0, ring_flags.e_empty, ring_flags.e_full, ring_flags.e_ovf});
  endtask : t_ring

  task automatic t_host_rst();
    host.hw(8'h04, 32'h0000_0010);
    er(8'h04, d);
    chk("engine_rdy_low", 32'h0, d & 32'h0000_0008);
    host.hr(8'h04, 1'b0, d);
    chk("host_rdy_low", 32'h0, d & 32'h0000_0008);
  endtask : t_host_rst

  task automatic t_part_reset();
    ew(8'h10, 32'h1000_0000);  // Interface idle while depth moves
    host.hr(8'h04, 1'b0, d);
    chk("depth_set", 32'h1000_0000, d & 32'hff00_0000);
    host.hw(8'h04, 32'h0000_0009);
    engine_partition_reset_n = 1'b0;
    @(negedge ref_clk);
    engine_partition_reset_n = 1'b1;
    er(8'h04, d);
    chk("engine_defaults", 32'h2000_0000, d);
    host.hr(8'h04, 1'b0, d);
    chk("host_kept", 32'h2000_0009, d & 32'hff00_0009);
    host.hw(8'h00, 32'h1234_5678);
    host.hr(8'h04, 1'b0, d);
    chk("write_dropped", 32'h0, d & 32'h00ff_0000);
  endtask : t_part_reset

  task automatic t_soft_reset();
    ew(8'h14, 32'h5a5a_0001);
    host.hr(8'h40, 1'b1, d);
    chk("fw_seen", 32'h5a5a_0001, d);
    ew(8'h10, 32'h1000_0000);
    ew(8'h04, 32'h2000_0008);
    ew(8'h00, 32'h0000_00ab);
    host.hr(8'h0c, 1'b0, d);
    chk("engine_word", 32'hab, d);
    host.hw(8'h00, 32'h0000_0001);
    host.going_down();
    host_soft_reset_n = 1'b0;
    @(negedge ref_clk);
    host_soft_reset_n = 1'b1;
    host.hr(8'h04, 1'b0, d);
    chk("host_cleared", 32'h1000_0000, d);
    er(8'h04, d);
    chk("engine_kept", 32'h0000_0008, d & 32'h0000_ff08);
    host.hr(8'h40, 1'b1, d);
    chk("fw_cleared", 32'h0, d);
  endtask : t_soft_reset

  task automatic results();
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    results();
  end

  initial
  begin
    srst = 1'b1;
    ereq = '0;
    engine_partition_reset_n = 1'b1;
    host_soft_reset_n = 1'b1;
    host_powered = 1'b1;
    bad_count = 0;
    n_tests = 0;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_engine_reset();
    t_ring();
    t_host_rst();
    t_part_reset();
    t_soft_reset();
    results();
  end
endmodule : mgmt_mailbox_ring_reset_tb
